// ==== verilog/dtc_map.vh ====
// dtc_map.vh: register map, field positions and timing counts
//
// What this block does
// - Write termination switching is on when either write-select bit is one.
// - Nominal code: off,/4,/2,/6,/12,/8; 110/111 reserved; /12,/8 barred in writes.
// - Write code: 00 switching off, 01 gives /4, 10 gives /2, 11 reserved.
// - With write termination off, writes never change the nominal strength.
// - Idle uses nominal strength; pin turns it on/off after fixed latencies.
// - Every write variant, chopped or full, triggers the switch when enabled.
// - Switch to write strength write latency minus two clocks after a write.
// - Return to nominal at off latency plus 6 (burst eight) or plus 4 (chop).
// - On/off state keeps following the pin and its latencies during writes.
// - Value is undefined for half a clock after each strength change.
// - Nominal timing parameters hold unchanged with dynamic switching on.
// - Termination turns on cas write latency plus additive latency minus two.
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// register byte offsets
`define DTC_CFG_OFS   8'h00
`define DTC_LAT_OFS   8'h04
`define DTC_STAT_OFS  8'h08
`define DTC_CNT_OFS   8'h0c

// configuration fields
`define DTC_NOM_LSB   0
`define DTC_NOM_MSB   2
`define DTC_WR_LSB    3
`define DTC_WR_MSB    4
`define DTC_CWL_LSB   0
`define DTC_CWL_MSB   3
`define DTC_AL_LSB    4
`define DTC_AL_MSB    8

// reset values
`define DTC_NOM_RST   3'h0
`define DTC_WR_RST    2'h0
`define DTC_CWL_RST   4'h5
`define DTC_AL_RST    5'h00

// status bit positions
`define DTC_ST_ON     0
`define DTC_ST_WRSEL  1
`define DTC_ST_UNSET  2
`define DTC_ST_DIV    4
`define DTC_ST_HOLDV  8
`define DTC_ST_NOMRES 9
`define DTC_ST_WRRES  10
`define DTC_ST_NOMWR  11

// timing counts in link clocks
`define DTC_LAT_SUB   6'h02
`define DTC_HOLD4     4'h4
`define DTC_HOLD8     4'h6
`define DTC_BACK4     6'h04
`define DTC_BACK8     6'h06

`endif

// ==== verilog/dtc_sync.v ====
// dtc_sync.v: two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module dtc_sync #(
  parameter W = 4
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rstn_i,
  // pins in, synchronised levels out
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= d_i[g];
          sync_reg <= meta_reg;
        end
      end
      assign q_o[g] = sync_reg;
    end
  endgenerate

endmodule

// ==== verilog/dtc_top.v ====
// dtc_top.v: dynamic write termination control with apb registers
`timescale 1ns/100ps
`include "dtc_map.vh"
module dtc_top #(
  parameter HIST = 32
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // memory link pins
  input  wire        ddr_ck_i,
  input  wire        term_pin_i,
  input  wire        wr_cmd_i,
  input  wire        chop_four_i,
  // termination control
  output wire        rtt_on_o,
  output wire [3:0]  rtt_div_o,
  output wire        rtt_write_o,
  output wire        rtt_unsettled_o
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  reg  [2:0]  nom_code_reg;
  reg  [1:0]  wr_code_reg;
  reg  [3:0]  cwl_reg;
  reg  [4:0]  al_reg;
  reg  [31:0] prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;
  reg  [15:0] sw_cnt_reg;

  reg         hold_viol_reg;
  reg         nom_res_reg;
  reg         wr_res_reg;
  reg         nom_wr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // link pin synchronisers

  wire [3:0] pin_s;

  dtc_sync #(
    .W (4)
  ) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({chop_four_i, wr_cmd_i, term_pin_i, ddr_ck_i}),
    .q_o    (pin_s)
  );

  wire ck_s   = pin_s[0];
  wire odt_s  = pin_s[1];
  wire wr_s   = pin_s[2];
  wire bc4_s  = pin_s[3];

  reg  ck_prev_reg;
  wire ck_rise = ck_s & ~ck_prev_reg;
  wire ck_fall = ~ck_s & ck_prev_reg;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ck_prev_reg <= 1'b0;
    end else begin
      ck_prev_reg <= ck_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  // write latency less two sets the on, off and switch delays alike
  wire [5:0] lat = {2'h0, cwl_reg} + {1'b0, al_reg} - `DTC_LAT_SUB;
  wire       dyn_en = wr_code_reg[0] | wr_code_reg[1];

  reg  [3:0] nom_div;
  reg  [3:0] wr_div;

  always @* begin
    case (nom_code_reg)
      3'h1:    nom_div = 4'h4;
      3'h2:    nom_div = 4'h2;
      3'h3:    nom_div = 4'h6;
      3'h4:    nom_div = 4'hc;
      3'h5:    nom_div = 4'h8;
      default: nom_div = 4'h0;
    endcase
  end

  always @* begin
    case (wr_code_reg)
      2'h1:    wr_div = 4'h4;
      2'h2:    wr_div = 4'h2;
      default: wr_div = 4'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // histories of registered pin and write, one entry per link clock

  reg [HIST-1:0] odt_hist_reg;
  reg [HIST-1:0] wr_hist_reg;
  reg [HIST-1:0] bc4_hist_reg;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      odt_hist_reg <= {HIST{1'b0}};
      wr_hist_reg  <= {HIST{1'b0}};
      bc4_hist_reg <= {HIST{1'b0}};
    end else if (ck_rise) begin
      odt_hist_reg <= {odt_hist_reg[HIST-2:0], odt_s};
      // every write variant arrives on the same strobe
      wr_hist_reg  <= {wr_hist_reg[HIST-2:0], wr_s};
      bc4_hist_reg <= {bc4_hist_reg[HIST-2:0], bc4_s};
    end
  end

  // write strength window per history entry
  wire [HIST-1:0] wr_win;

  genvar i;
  generate
    for (i = 0; i < HIST; i = i + 1) begin : g_age
      localparam [5:0] age = i;
      wire [5:0] back = bc4_hist_reg[i] ? `DTC_BACK4 : `DTC_BACK8;
      // from lat up to lat plus 4 or 6, fixed or on-the-fly length
      assign wr_win[i] = wr_hist_reg[i] & (age >= lat) &
                         (age < lat + back);
    end
  endgenerate

  wire in_write = |wr_win;
  // on/off follows the pin alone, also during writes
  wire term_on  = odt_hist_reg[lat[4:0]];
  wire use_wr   = dyn_en & in_write;
  wire [3:0] div_now = use_wr ? wr_div : nom_div;

  ////////////////////////////////////////////////////////////////////////////
  // termination outputs

  reg       rtt_on_reg;
  reg [3:0] rtt_div_reg;
  reg       rtt_write_reg;
  reg       unset_reg;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rtt_on_reg    <= 1'b0;
      rtt_div_reg   <= 4'h0;
      rtt_write_reg <= 1'b0;
    end else begin
      rtt_on_reg    <= term_on;
      rtt_div_reg   <= div_now;
      rtt_write_reg <= use_wr;
    end
  end

  // a strength change opens a half-clock window ended by the next falling
  // link edge; a change in that same cycle keeps it open
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unset_reg <= 1'b0;
    end else if (div_now != rtt_div_reg) begin
      unset_reg <= 1'b1;
    end else if (ck_fall) begin
      unset_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin hold watch: flags a controller that drops the pin too early

  reg  [3:0] hold_cnt_reg;
  reg  [3:0] hold_cnt_next;
  reg        hold_bad;
  wire [3:0] wr_hold = bc4_s ? `DTC_HOLD4 : `DTC_HOLD8;

  always @* begin
    hold_cnt_next = hold_cnt_reg;
    hold_bad      = 1'b0;
    if (ck_rise) begin
      if (!odt_s) begin
        hold_bad      = hold_cnt_reg != 4'h0;
        hold_cnt_next = 4'h0;
      end else begin
        if (hold_cnt_next != 4'h0) begin
          hold_cnt_next = hold_cnt_next - 4'h1;
        end
        if (!odt_hist_reg[0] && hold_cnt_next < `DTC_HOLD4 - 4'h1) begin
          hold_cnt_next = `DTC_HOLD4 - 4'h1;
        end
        // the later deadline of pin-high and write-with-pin-high wins
        if (wr_s && hold_cnt_next < wr_hold - 4'h1) begin
          hold_cnt_next = wr_hold - 4'h1;
        end
      end
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_cnt_reg <= 4'h0;
    end else begin
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer on the second access cycle

  wire acc     = psel_i & penable_i;
  wire commit  = acc & pready_reg;
  wire wr_ev   = commit & pwrite_i;
  wire rd_ev   = commit & ~pwrite_i;
  wire hit_cfg = paddr_i == `DTC_CFG_OFS;
  wire hit_lat = paddr_i == `DTC_LAT_OFS;
  wire hit_st  = paddr_i == `DTC_STAT_OFS;
  wire hit_cnt = paddr_i == `DTC_CNT_OFS;
  wire mapped  = hit_cfg | hit_lat | hit_st | hit_cnt;
  wire clr_st  = wr_ev & hit_st;

  wire [31:0] stat_word;
  assign stat_word = {20'h0, nom_wr_reg, wr_res_reg, nom_res_reg,
                      hold_viol_reg, rtt_div_reg, 1'b0, unset_reg,
                      rtt_write_reg, rtt_on_reg};

  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0;
    if (hit_cfg) begin
      rd_mux[`DTC_NOM_MSB:`DTC_NOM_LSB] = nom_code_reg;
      rd_mux[`DTC_WR_MSB:`DTC_WR_LSB]   = wr_code_reg;
    end else if (hit_lat) begin
      rd_mux[`DTC_CWL_MSB:`DTC_CWL_LSB] = cwl_reg;
      rd_mux[`DTC_AL_MSB:`DTC_AL_LSB]   = al_reg;
    end else if (hit_st) begin
      rd_mux = stat_word;
    end else if (hit_cnt) begin
      rd_mux = {16'h0, sw_cnt_reg};
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= acc & ~pready_reg;
      pslverr_reg <= acc & ~pready_reg & ~mapped;
      prdata_reg  <= (acc & ~pready_reg & ~pwrite_i) ? rd_mux : 32'h0;
    end
  end

  // configuration takes effect at the completing edge only
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nom_code_reg <= `DTC_NOM_RST;
      wr_code_reg  <= `DTC_WR_RST;
      cwl_reg      <= `DTC_CWL_RST;
      al_reg       <= `DTC_AL_RST;
    end else if (wr_ev && hit_cfg) begin
      nom_code_reg <= pwdata_i[`DTC_NOM_MSB:`DTC_NOM_LSB];
      wr_code_reg  <= pwdata_i[`DTC_WR_MSB:`DTC_WR_LSB];
    end else if (wr_ev && hit_lat) begin
      cwl_reg      <= pwdata_i[`DTC_CWL_MSB:`DTC_CWL_LSB];
      al_reg       <= pwdata_i[`DTC_AL_MSB:`DTC_AL_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky error flags, write one to clear, a new event wins over the clear

  wire nom_res_ev = nom_code_reg[2] & nom_code_reg[1];
  wire wr_res_ev  = wr_code_reg == 2'h3;
  // /12 and /8 may not be used as the write strength
  wire nom_wr_ev  = ~dyn_en & in_write & nom_code_reg[2];

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_viol_reg <= 1'b0;
      nom_res_reg   <= 1'b0;
      wr_res_reg    <= 1'b0;
      nom_wr_reg    <= 1'b0;
    end else begin
      hold_viol_reg <= hold_bad |
                       (hold_viol_reg & ~(clr_st & pwdata_i[`DTC_ST_HOLDV]));
      nom_res_reg   <= nom_res_ev |
                       (nom_res_reg & ~(clr_st & pwdata_i[`DTC_ST_NOMRES]));
      wr_res_reg    <= wr_res_ev |
                       (wr_res_reg & ~(clr_st & pwdata_i[`DTC_ST_WRRES]));
      nom_wr_reg    <= nom_wr_ev |
                       (nom_wr_reg & ~(clr_st & pwdata_i[`DTC_ST_NOMWR]));
    end
  end

  // count of entries into write strength, write any value to clear
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sw_cnt_reg <= 16'h0;
    end else if (use_wr && !rtt_write_reg) begin
      sw_cnt_reg <= sw_cnt_reg + 16'h1;
    end else if (wr_ev && hit_cnt) begin
      sw_cnt_reg <= 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata_o        = prdata_reg;
  assign pready_o        = pready_reg;
  assign pslverr_o       = pslverr_reg;
  assign rtt_on_o        = rtt_on_reg;
  assign rtt_div_o       = rtt_div_reg;
  assign rtt_write_o     = rtt_write_reg;
  assign rtt_unsettled_o = unset_reg;

endmodule

// ==== dv/dtc_sva.sv ====
// dtc_sva.sv: port timing checks for the termination block
`timescale 1ns/100ps
module dtc_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rstn_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // link and termination
  input wire logic        ddr_ck_i,
  input wire logic        rtt_on_o,
  input wire logic [3:0]  rtt_div_o,
  input wire logic        rtt_write_o,
  input wire logic        rtt_unsettled_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] wcnt;
  // saturating width count of the write-strength window
  always @(posedge clk_i or negedge rstn_i)
    if (!rstn_i) wcnt <= 8'h00;
    else wcnt <= rtt_write_o ? wcnt + {7'h00, wcnt != 8'hff} : 8'h00;
  sequence s_wait;
    !pready_o ##1 pready_o;
  endsequence
  sequence s_settle;
    rtt_unsettled_o [*4] ##[1:12] !rtt_unsettled_o;
  endsequence
  a_apb_wait: assert property ($rose(penable_i) && psel_i |-> s_wait)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held longer than one cycle");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("slave error without pready");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data nonzero outside answer");
  a_on_at_ck: assert property ($changed(rtt_on_o) |-> ddr_ck_i)
    else $error("termination on changed away from link edge");
  a_write_at_ck: assert property ($changed(rtt_write_o)
    |-> ddr_ck_i && $past(ddr_ck_i, 2))
    else $error("strength switched away from link edge");
  a_write_div: assert property (rtt_write_o
    |-> rtt_div_o inside {4'h0, 4'h2, 4'h4})
    else $error("write strength not a legal value");
  a_change_skew: assert property ($changed(rtt_div_o) |-> rtt_unsettled_o)
    else $error("strength change without unsettled flag");
  a_skew_len: assert property ($rose(rtt_unsettled_o)
    && $changed(rtt_write_o) |-> s_settle)
    else $error("unsettled window wrong length");
  a_write_width: assert property ($fell(rtt_write_o) |-> wcnt >= 8'd75)
    else $error("write strength window under four link clocks");
endmodule
bind dtc_top dtc_sva dtc_sva_i (
  .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ddr_ck_i(ddr_ck_i), .rtt_on_o(rtt_on_o), .rtt_div_o(rtt_div_o),
  .rtt_write_o(rtt_write_o), .rtt_unsettled_o(rtt_unsettled_o)
);

// ==== dv/dtc_ctrl_model.sv ====
// dtc_ctrl_model.sv: memory controller driving link clock and pins
`timescale 1ns/100ps
module dtc_ctrl_model (
  // system clock
  input  wire logic clk_i,
  // link pins toward the device
  output logic      ddr_ck_o,
  output logic      term_pin_o,
  output logic      wr_cmd_o,
  output logic      chop_four_o
);
  logic [4:0] ph_reg;
  initial begin
    ph_reg = 5'h00;
    ddr_ck_o = 1'b0;
    term_pin_o = 1'b0;
    wr_cmd_o = 1'b0;
    chop_four_o = 1'b0;
  end
  // 80 ns link clock, pins move mid low phase to keep margin both sides
  always @(posedge clk_i) begin
    ph_reg <= (ph_reg == 5'h13) ? 5'h00 : ph_reg + 5'h01;
    ddr_ck_o <= (ph_reg == 5'h13) || (ph_reg < 5'h09);
  end
  // one link clock: pins set, then returns seven clocks after the rise
  task automatic step(input logic p, input logic w, input logic c);
    do @(posedge clk_i); while (ph_reg != 5'h0e);
    term_pin_o <= p;
    wr_cmd_o <= w;
    chop_four_o <= c;
    do @(posedge clk_i); while (ph_reg != 5'h06);
  endtask
endmodule

// ==== dv/dtc_top_test.sv ====
// dtc_top_test.sv: self-checking bench for the termination block
`timescale 1ns/100ps
module dtc_top_test;
  logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic        pready_o, pslverr_o, ddr_ck, term_pin, wr_cmd, chop;
  logic        rtt_on_o, rtt_write_o, rtt_unsettled_o;
  logic [3:0]  rtt_div_o;
  logic [3:0]  dt [8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hc, 4'h8, 4'h0, 4'h0};
  int          failures = 0;
  int          check_count = 0;
  initial {clk_i, rstn_i, psel_i, penable_i, pwrite_i} = 5'h00;
  initial {paddr_i, pwdata_i} = 40'h0;
  always #2 clk_i = ~clk_i;
  dtc_top dtc_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ddr_ck_i(ddr_ck), .term_pin_i(term_pin),
    .wr_cmd_i(wr_cmd), .chop_four_i(chop), .rtt_on_o(rtt_on_o),
    .rtt_div_o(rtt_div_o), .rtt_write_o(rtt_write_o),
    .rtt_unsettled_o(rtt_unsettled_o));
  dtc_ctrl_model mdl_i (.clk_i(clk_i), .ddr_ck_o(ddr_ck),
    .term_pin_o(term_pin), .wr_cmd_o(wr_cmd), .chop_four_o(chop));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 40);
    if (n >= 40) failures++;
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // one write at link edge 0 with the pin held exactly its minimum
  task automatic run(input logic [2:0] nom, input logic [1:0] wc,
                     input logic c, input logic [4:0] al);
    int L, h;
    logic [31:0] r;
    logic e, on, we;
    logic [3:0] xd, pd;
    L = 3 + al;
    h = c ? 4 : 6;
    pd = dt[nom];
    apb(1'b1, 8'h00, {27'h0, wc, nom}, r, e);
    apb(1'b1, 8'h04, {23'h0, al, 4'h5}, r, e);
    for (int k = 0; k < L + 8; k++) begin
      mdl_i.step(k < h, k == 0, c);
      on = k >= L && k < L + h;
      we = on && wc != 2'h0;
      chk("rtt_on", on, rtt_on_o);
      chk("rtt_write", we, rtt_write_o);
      xd = we ? (wc == 2'h1 ? 4'h4 : wc == 2'h2 ? 4'h2 : 4'h0) : dt[nom];
      chk("rtt_div", xd, rtt_div_o);
      chk("rtt_unsettled", xd != pd, rtt_unsettled_o);
      pd = xd;
    end
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h00, 32'h0, r, e);
    chk("cfg reset", 32'h0, r);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("lat reset", 32'h5, r);
    apb(1'b1, 8'h10, 32'h1, r, e);
    chk("unmapped err", 32'h1, e);
    apb(1'b1, 8'h04, 32'hf6, r, e);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("lat rw", 32'hf6, r);
  endtask
  task automatic t_nominal;
    logic [31:0] r;
    logic e;
    for (int n = 0; n < 8; n++) run(n[2:0], 2'h0, 1'b0, 5'h0);
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk("flags", 32'ha, r[11:8]);
    // a reserved nominal code keeps raising its flag, so leave it first
    apb(1'b1, 8'h00, 32'h0, r, e);
    apb(1'b1, 8'h08, 32'hf00, r, e);
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk("flags clear", 32'h0, r[11:8]);
  endtask
  task automatic t_dynamic;
    logic [31:0] r;
    logic e;
    for (int w = 1; w < 4; w++) begin
      run(3'h2, w[1:0], 1'b0, 5'h0);
      run(3'h2, w[1:0], 1'b1, 5'h0);
    end
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk("write code flag", 32'h1, r[10]);
    chk("status", 32'h20, r[7:0]);
    apb(1'b0, 8'h0c, 32'h0, r, e);
    chk("switch count", 32'h6, r);
    apb(1'b1, 8'h0c, 32'h0, r, e);
    apb(1'b0, 8'h0c, 32'h0, r, e);
    chk("count clear", 32'h0, r);
  endtask
  // burst-eight write with the pin dropped after four link clocks
  task automatic t_hold;
    logic [31:0] r;
    logic e;
    for (int k = 0; k < 8; k++) mdl_i.step(k < 4, k == 0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk("hold flag", 32'h1, r[8]);
  endtask
  task automatic t_latency;
    run(3'h3, 2'h1, 1'b1, 5'h2);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_nominal();
    t_dynamic();
    t_latency();
    t_hold();
    conclude();
  end
  // runs take about 4000 clocks
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule
